// file: logic/bomt_transceiver.sv
// Codeword message transceiver: registers, receive qualifier, transmit arbiter
// Assumes bit enables from the framer timebases on sys_clk, link inputs on sys_clk
`timescale 1ns/1ns
module bomt_transceiver
  import bomt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire bomt_pkg::bomt_cpu_t cpu,
  output logic [7:0] cpu_rdata,
  input wire logic rx_bit_en,
  input wire logic rx_bit,
  input wire logic tx_bit_en,
  input wire logic link_tx_bit,
  input wire logic link_buf_empty,
  input wire logic link_idle,
  input wire logic report_pending,
  output logic tx_bit,
  output logic link_abort,
  output logic link_hold,
  output logic rx_irq,
  output logic tx_irq
);
  import bomt_pkg::*;

  typedef enum logic [1:0] {
    BOMT_TX_IDLE = 2'b00,
    BOMT_TX_WAIT = 2'b01,
    BOMT_TX_SEND = 2'b10
  } bomt_tx_state_t;

  logic [7:0] ctrl_reg;
  logic [5:0] rx_code_reg;
  logic rx_valid_reg;
  logic rx_over_reg;
  logic rx_act_reg;
  logic [5:0] cand_reg;
  logic [4:0] cnt_reg;
  logic [5:0] tx_code_reg;
  logic tx_pend_reg;
  logic [4:0] tx_cnt_reg;
  logic tx_act_reg;
  logic [3:0] abort_cnt_reg;
  bomt_tx_state_t tx_state_reg;
  logic pat_hit;
  logic [5:0] pat_code;
  logic pat_abut;
  logic ser_busy;
  logic ser_bit;
  logic ser_last;
  logic ser_start;
  logic wr_ctrl;
  logic wr_txcw;
  logic rd_rxcw;
  logic [1:0] rx_len;
  logic [1:0] tx_len;
  logic [1:0] tx_mode;
  logic integ;
  logic [4:0] rx_need;
  logic qualify;
  logic tx_grant;

  assign wr_ctrl = cpu.wr && (cpu.addr == BOMT_ADDR_CTRL);
  assign wr_txcw = cpu.wr && (cpu.addr == BOMT_ADDR_TXCW);
  assign rd_rxcw = cpu.rd && (cpu.addr == BOMT_ADDR_RXCW);
  assign rx_len = ctrl_reg[BOMT_CTRL_RXLEN_LSB +: 2];
  assign tx_len = ctrl_reg[BOMT_CTRL_TXLEN_LSB +: 2];
  assign tx_mode = ctrl_reg[BOMT_CTRL_MODE_LSB +: 2];
  assign integ = ctrl_reg[BOMT_CTRL_INTEG_BIT];

  // ----------------------------------------------------------------
  // Processor port
  // ----------------------------------------------------------------
  // Control register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg <= BOMT_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= cpu.wdata;
    end
  end

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cpu_rdata <= 8'h00;
    end else if (cpu.rd) begin
      unique case (cpu.addr)
        BOMT_ADDR_CTRL: cpu_rdata <= ctrl_reg;
        BOMT_ADDR_RXCW: cpu_rdata <= {rx_over_reg, rx_valid_reg, rx_code_reg};
        BOMT_ADDR_STAT: cpu_rdata <= {tx_act_reg, rx_act_reg, 6'h00};
        default: cpu_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive qualifier
  // ----------------------------------------------------------------
  bomt_rx_detect u_rx_detect (
    .sys_clk(sys_clk),
    .rst(rst),
    .enable(ctrl_reg[BOMT_CTRL_RXEN_BIT]),
    .bit_en(rx_bit_en),
    .bit_in(rx_bit),
    .pat_hit(pat_hit),
    .pat_code(pat_code),
    .pat_abut(pat_abut)
  );

  // Threshold in counted patterns, plus one under integration
  assign rx_need = bomt_len_count(rx_len) + (integ ? 5'h01 : 5'h00);

  // Count identical patterns; a differing codeword restarts the count
  always_ff @(posedge sys_clk) begin
    if (rst || !ctrl_reg[BOMT_CTRL_RXEN_BIT]) begin
      cand_reg <= 6'h00;
      cnt_reg <= 5'h00;
      rx_act_reg <= 1'b0;
      qualify <= 1'b0;
    end else begin
      qualify <= 1'b0;
      if (pat_hit) begin
        if (rx_len == BOMT_LEN_CONT) begin
          // Update on change: new codeword qualifies at once
          cand_reg <= pat_code;
          qualify <= (pat_code != rx_code_reg) || (cnt_reg == 5'h00);
          cnt_reg <= 5'h01;
        end else if (pat_code != cand_reg || cnt_reg == 5'h00 ||
                     (integ && !pat_abut)) begin
          cand_reg <= pat_code;
          cnt_reg <= 5'h01;
          qualify <= (rx_need == 5'h01);
          rx_act_reg <= (rx_need > 5'h02);
        end else if (cnt_reg + 5'h01 >= rx_need) begin
          cnt_reg <= 5'h00;
          qualify <= 1'b1;
          rx_act_reg <= 1'b0;
        end else begin
          cnt_reg <= cnt_reg + 5'h01;
        end
      end
    end
  end

  // Stored codeword and flags; a load sets valid over a read clear, but a read in the same cycle clears overrun
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_code_reg <= 6'h00;
      rx_valid_reg <= 1'b0;
      rx_over_reg <= 1'b0;
      rx_irq <= 1'b0;
    end else begin
      rx_irq <= qualify;
      if (qualify) begin
        rx_code_reg <= cand_reg;
        rx_valid_reg <= 1'b1;
        if (rx_valid_reg && !rd_rxcw) begin
          rx_over_reg <= 1'b1;
        end else if (rd_rxcw) begin
          rx_over_reg <= 1'b0;
        end
      end else if (rd_rxcw) begin
        rx_valid_reg <= 1'b0;
        rx_over_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit message sequencer
  // ----------------------------------------------------------------
  bomt_tx_pattern u_tx_pattern (
    .sys_clk(sys_clk),
    .rst(rst),
    .bit_en(tx_bit_en),
    .start(ser_start),
    .code(tx_code_reg),
    .busy(ser_busy),
    .bit_out(ser_bit),
    .last_bit(ser_last)
  );

  // Channel grant: reports first, then codewords by mode
  assign tx_grant = !report_pending && ((tx_mode == BOMT_MODE_CW_PRIO) ||
                    (link_buf_empty && link_idle));
  assign ser_start = (tx_state_reg == BOMT_TX_SEND) && !ser_busy && tx_grant;

  // Pending flag clear condition: idle, or waiting with the channel granted; the state machine does not use it
  function automatic logic tx_irq_next();
    tx_irq_next = (tx_state_reg == BOMT_TX_IDLE) ||
                  ((tx_state_reg == BOMT_TX_WAIT) && tx_grant);
  endfunction

  // Pending codeword, taken only when the transmitter is enabled
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_code_reg <= 6'h00;
      tx_pend_reg <= 1'b0;
    end else if (wr_txcw && tx_mode[1]) begin
      tx_code_reg <= cpu.wdata[5:0];
      tx_pend_reg <= 1'b1;
    end else if (tx_state_reg != BOMT_TX_SEND && tx_pend_reg && tx_irq_next()) begin
      tx_pend_reg <= 1'b0;
    end
  end

  // Pattern count, active status and start interrupt
  always_ff @(posedge sys_clk) begin
    if (rst || !tx_mode[1]) begin
      tx_state_reg <= BOMT_TX_IDLE;
      tx_cnt_reg <= 5'h00;
      tx_act_reg <= 1'b0;
      tx_irq <= 1'b0;
    end else begin
      tx_irq <= 1'b0;
      unique case (tx_state_reg)
        BOMT_TX_IDLE: begin
          if (tx_pend_reg) begin
            tx_state_reg <= BOMT_TX_WAIT;
          end
        end
        BOMT_TX_WAIT: begin
          if (tx_grant) begin
            tx_state_reg <= BOMT_TX_SEND;
            tx_cnt_reg <= 5'h00;
            tx_act_reg <= 1'b1;
            tx_irq <= 1'b1;
          end
        end
        BOMT_TX_SEND: begin
          if (ser_last) begin
            if (tx_len != BOMT_LEN_CONT &&
                tx_cnt_reg + 5'h01 >= bomt_len_count(tx_len)) begin
              tx_act_reg <= 1'b0;
              tx_state_reg <= BOMT_TX_IDLE;
            end else begin
              tx_cnt_reg <= tx_cnt_reg + 5'h01;
            end
          end
        end
        default: tx_state_reg <= BOMT_TX_IDLE;
      endcase
    end
  end

  // Link abort under codeword priority, counted in bit times
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      abort_cnt_reg <= 4'h0;
      link_abort <= 1'b0;
    end else if (tx_state_reg == BOMT_TX_IDLE || tx_mode != BOMT_MODE_CW_PRIO) begin
      abort_cnt_reg <= 4'h0;
      link_abort <= 1'b0;
    end else if (tx_bit_en && abort_cnt_reg != 4'(BOMT_ABORT_BITS - 1)) begin
      abort_cnt_reg <= abort_cnt_reg + 4'h1;
    end else if (abort_cnt_reg == 4'(BOMT_ABORT_BITS - 1)) begin
      link_abort <= 1'b1;
    end
  end

  // Output mux: codeword bits only mid-pattern, so yielding waits for a boundary
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_bit <= 1'b1;
      link_hold <= 1'b0;
    end else begin
      link_hold <= ser_busy || ((tx_state_reg == BOMT_TX_SEND) && tx_grant);
      tx_bit <= ser_busy ? ser_bit : link_tx_bit;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_irq_with_load: assert property (@(posedge sys_clk) disable iff (rst)
    qualify |=> rx_irq && rx_valid_reg && rx_code_reg == $past(cand_reg))
    else $error("receive load and interrupt not together");
  chk_overrun_set: assert property (@(posedge sys_clk) disable iff (rst)
    qualify && rx_valid_reg && !rd_rxcw |=> rx_over_reg)
    else $error("overrun flag not set");
  chk_valid_clear: assert property (@(posedge sys_clk) disable iff (rst)
    rd_rxcw && !qualify |=> !rx_valid_reg)
    else $error("valid flag not cleared on read");
  chk_rx_disabled: assert property (@(posedge sys_clk) disable iff (rst)
    !ctrl_reg[BOMT_CTRL_RXEN_BIT] |=> !qualify && !rx_act_reg)
    else $error("receiver active while disabled");
  chk_ignore_writes: assert property (@(posedge sys_clk) disable iff (rst)
    wr_txcw && !tx_mode[1] && !tx_pend_reg |=> !tx_pend_reg)
    else $error("codeword write taken while disabled");
  chk_start_irq: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(tx_act_reg) |-> tx_irq)
    else $error("no transmit interrupt at message start");
  chk_report_first: assert property (@(posedge sys_clk) disable iff (rst)
    report_pending |-> !ser_start)
    else $error("codeword started over a pending report");
  chk_link_pause: assert property (@(posedge sys_clk) disable iff (rst)
    tx_mode == BOMT_MODE_DL_PRIO && !link_buf_empty |-> !ser_start)
    else $error("codeword started with link buffer full");
  chk_single_len: assert property (@(posedge sys_clk) disable iff (rst)
    rx_len == BOMT_LEN_1 && !integ && !rx_act_reg |=> !rx_act_reg)
    else $error("receive active toggled for threshold one");
  cov_rx_qualify: cover property (@(posedge sys_clk) disable iff (rst) rx_irq);
  cov_rx_overrun: cover property (@(posedge sys_clk) disable iff (rst) $rose(rx_over_reg));
  cov_tx_start: cover property (@(posedge sys_clk) disable iff (rst) tx_irq);
  cov_tx_abort: cover property (@(posedge sys_clk) disable iff (rst) link_abort);
endmodule // bomt_transceiver

// file: logic/bomt_pkg.sv
// Constants, register map and carriers for the codeword transceiver
// Assumes an 8-bit processor port with a one-cycle read and write strobe
package bomt_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] BOMT_ADDR_CTRL = 8'hA0;
  localparam logic [7:0] BOMT_ADDR_TXCW = 8'hA1;
  localparam logic [7:0] BOMT_ADDR_RXCW = 8'hA2;
  localparam logic [7:0] BOMT_ADDR_STAT = 8'hA3;
  localparam logic [7:0] BOMT_CTRL_RESET = 8'h00;
  // Control field positions
  localparam int BOMT_CTRL_RXEN_BIT = 7;
  localparam int BOMT_CTRL_INTEG_BIT = 6;
  localparam int BOMT_CTRL_RXLEN_LSB = 4;
  localparam int BOMT_CTRL_TXLEN_LSB = 2;
  localparam int BOMT_CTRL_MODE_LSB = 0;
  // Receive codeword and status bits
  localparam int BOMT_RX_OVERRUN_BIT = 7;
  localparam int BOMT_RX_VALID_BIT = 6;
  localparam int BOMT_STAT_TXACT_BIT = 7;
  localparam int BOMT_STAT_RXACT_BIT = 6;
  // ----------------------------------------------------------------
  // Pattern and timing
  // ----------------------------------------------------------------
  localparam int BOMT_PAT_BITS = 16;
  localparam logic [7:0] BOMT_FLAG_ONES = 8'hFF;
  localparam int BOMT_ABORT_BITS = 8;
  localparam logic [4:0] BOMT_CNT_ONE = 5'h01;
  localparam logic [4:0] BOMT_CNT_TEN = 5'h0A;
  localparam logic [4:0] BOMT_CNT_TWENTYFIVE = 5'h19;
  // Length selector and mode codes
  localparam logic [1:0] BOMT_LEN_1 = 2'h0;
  localparam logic [1:0] BOMT_LEN_10 = 2'h1;
  localparam logic [1:0] BOMT_LEN_25 = 2'h2;
  localparam logic [1:0] BOMT_LEN_CONT = 2'h3;
  localparam logic [1:0] BOMT_MODE_CW_PRIO = 2'h2;
  localparam logic [1:0] BOMT_MODE_DL_PRIO = 2'h3;
  // Carrier for the processor port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bomt_cpu_t;
  // Decode of a length selector into a pattern count
  function automatic logic [4:0] bomt_len_count(input logic [1:0] sel);
    unique case (sel)
      BOMT_LEN_10: bomt_len_count = BOMT_CNT_TEN;
      BOMT_LEN_25: bomt_len_count = BOMT_CNT_TWENTYFIVE;
      default: bomt_len_count = BOMT_CNT_ONE;
    endcase
  endfunction
endpackage

// file: logic/bomt_rx_detect.sv
// Pattern detector for the receive data link bit stream
// Assumes bits arrive with a one-cycle enable on the system clock
`timescale 1ns/1ns
module bomt_rx_detect
  import bomt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic bit_en,
  input wire logic bit_in,
  output logic pat_hit,
  output logic [5:0] pat_code,
  output logic pat_abut
);
  logic [15:0] shift_reg;
  logic [4:0] since_reg;
  logic [15:0] shift_next;
  logic match;

  // Newest bit enters at the top; first-sent bit ends up at bit 0
  assign shift_next = {bit_in, shift_reg[15:1]};
  assign match = (shift_next[7:0] == BOMT_FLAG_ONES) && !shift_next[8] && !shift_next[15];

  // ----------------------------------------------------------------
  // Shift and match
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst || !enable) begin
      shift_reg <= 16'h0000;
      since_reg <= 5'h1F;
      pat_hit <= 1'b0;
      pat_code <= 6'h00;
      pat_abut <= 1'b0;
    end else begin
      pat_hit <= 1'b0;
      if (bit_en) begin
        shift_reg <= shift_next;
        if (since_reg != 5'h1F) begin
          since_reg <= since_reg + 5'h01;
        end
        if (match) begin
          pat_hit <= 1'b1;
          pat_code <= shift_next[14:9];
          // Abutting means the previous pattern ended exactly 16 bits ago
          pat_abut <= (since_reg == 5'(BOMT_PAT_BITS - 1));
          since_reg <= 5'h00;
        end
      end
    end
  end
endmodule // bomt_rx_detect

// file: logic/bomt_tx_pattern.sv
// Serialiser that emits codeword patterns one bit per bit enable
// Assumes the caller holds start high only while idle
`timescale 1ns/1ns
module bomt_tx_pattern
  import bomt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic bit_en,
  input wire logic start,
  input wire logic [5:0] code,
  output logic busy,
  output logic bit_out,
  output logic last_bit
);
  logic [15:0] pat_reg;
  logic [3:0] idx_reg;

  // ----------------------------------------------------------------
  // Serialiser
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pat_reg <= 16'h0000;
      idx_reg <= 4'h0;
      busy <= 1'b0;
    end else if (start && !busy) begin
      pat_reg <= {1'b0, code, 1'b0, BOMT_FLAG_ONES};
      idx_reg <= 4'h0;
      busy <= 1'b1;
    end else if (busy && bit_en) begin
      idx_reg <= idx_reg + 4'h1;
      if (idx_reg == 4'hF) begin
        busy <= 1'b0;
      end
    end
  end

  assign bit_out = pat_reg[idx_reg];
  assign last_bit = busy && bit_en && (idx_reg == 4'hF);
endmodule // bomt_tx_pattern

// file: verification/bomt_far_end.sv
// Far-end line equipment: sends codeword patterns, decodes what we send
// Assumes one bit enable every fourth clock in each direction
`timescale 1ns/1ns
module bomt_far_end (
  input wire logic sys_clk,
  input wire logic rst,
  output logic rx_bit_en,
  output logic rx_bit,
  output logic tx_bit_en,
  input wire logic tx_bit
);
  logic q[$];
  logic [1:0] ph;
  logic [15:0] sh;
  logic [15:0] w;
  logic [5:0] last_code;
  int n_pat;
  int n_flag;
  // Queue gap bits, then patterns: flag, zero, code LSB first, zero
  task automatic push(input logic [5:0] code, input int n, input int gap);
    for (int i = 0; i < gap; i++) q.push_back(i[0]);
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 8; i++) q.push_back(1'b1);
      q.push_back(1'b0);
      for (int i = 0; i < 6; i++) q.push_back(code[i]);
      q.push_back(1'b0);
    end
  endtask
  // Wait until at most n bits are still queued
  task automatic wait_left(input int n);
    while (q.size() > n) @(posedge sys_clk);
  endtask
  // Newest bit seen on our receive side enters the window at the top
  assign w = {tx_bit, sh[15:1]};
  initial begin
    ph = 2'h0;
    rx_bit_en = 1'b0;
    rx_bit = 1'b0;
    tx_bit_en = 1'b0;
    sh = 16'h0000;
  end
  // Bit enables; an empty queue idles the line with alternating bits
  always @(posedge sys_clk) begin
    ph <= rst ? 2'h0 : ph + 2'h1;
    rx_bit_en <= (ph == 2'h3);
    tx_bit_en <= (ph == 2'h1);
    if (ph == 2'h3) rx_bit <= (q.size() != 0) ? q.pop_front() : ~rx_bit;
    // Sample one clock after the bit enable, once the registered bit has settled
    if (ph == 2'h3) begin
      sh <= w;
      // A flag counts once its closing zero has arrived
      if (w[15] == 1'b0 && w[14:7] == 8'hFF) n_flag <= n_flag + 1;
      if (w[15] == 1'b0 && w[8] == 1'b0 && w[7:0] == 8'hFF) begin
        n_pat <= n_pat + 1;
        last_code <= w[14:9];
      end
    end
  end
endmodule // bomt_far_end

// file: verification/tb_bomt_transceiver.sv
// Self-checking bench for the codeword transceiver
// Assumes the package, the design and the far-end model compile first
`timescale 1ns/1ns
// Compare, count and report one value
`define CHK(name, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("ERROR %s expected %0h seen %0h", name, exp, got); \
    end \
  end
module tb_bomt_transceiver;
  import bomt_pkg::*;
  localparam int LIMIT = 60000;
  logic sys_clk;
  logic rst;
  bomt_cpu_t cpu;
  logic [7:0] cpu_rdata;
  logic rx_bit_en, rx_bit, tx_bit_en, tx_bit;
  logic link_tx_bit, link_buf_empty, link_idle, report_pending;
  logic link_abort, link_hold, rx_irq, tx_irq;
  int n_errors, checked, cycles, n_rx_irq, n_tx_irq;
  bomt_transceiver dut (
    .sys_clk(sys_clk), .rst(rst), .cpu(cpu), .cpu_rdata(cpu_rdata),
    .rx_bit_en(rx_bit_en), .rx_bit(rx_bit), .tx_bit_en(tx_bit_en),
    .link_tx_bit(link_tx_bit), .link_buf_empty(link_buf_empty), .link_idle(link_idle),
    .report_pending(report_pending), .tx_bit(tx_bit), .link_abort(link_abort),
    .link_hold(link_hold), .rx_irq(rx_irq), .tx_irq(tx_irq)
  );
  bomt_far_end far (
    .sys_clk(sys_clk), .rst(rst), .rx_bit_en(rx_bit_en), .rx_bit(rx_bit),
    .tx_bit_en(tx_bit_en), .tx_bit(tx_bit)
  );
  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Data link transmitter stand-in: alternating bits, one per bit enable
  always @(posedge sys_clk) begin
    if (rst) link_tx_bit <= 1'b0;
    else if (tx_bit_en === 1'b1) link_tx_bit <= ~link_tx_bit;
  end
  // Count interrupt pulses and cut a hang short
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (rx_irq === 1'b1) n_rx_irq <= n_rx_irq + 1;
    if (tx_irq === 1'b1) n_tx_irq <= n_tx_irq + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("Checks %0d, errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cpu <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    cpu <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    cpu <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    cpu <= '0;
    // Read data stands from the edge after the strobe
    @(posedge sys_clk);
    v = cpu_rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    `CHK("cpu_rdata", exp, v)
  endtask
  // Poll status until the transmitter is no longer active
  task automatic tx_wait();
    logic [7:0] v;
    v = 8'h80;
    for (int i = 0; i < 4000 && v[7] !== 1'b0; i++) rd(BOMT_ADDR_STAT, v);
  endtask
  task automatic wait_pats(input int n);
    for (int i = 0; i < 3000 && far.n_pat < n; i++) @(posedge sys_clk);
  endtask
  // Abutting patterns: none qualify before the last, the last does
  task automatic rx_case(input logic [7:0] ctl, input logic [5:0] code, input int need);
    int base;
    base = n_rx_irq;
    wr(BOMT_ADDR_CTRL, ctl);
    far.push(code, need, 3);
    far.wait_left(14);
    `CHK("rx_irq", base, n_rx_irq)
    rd_chk(BOMT_ADDR_STAT, (need > 2) ? 8'h40 : 8'h00);
    far.wait_left(0);
    cyc(8);
    `CHK("rx_irq", base + 1, n_rx_irq)
    rd_chk(BOMT_ADDR_RXCW, {2'b01, code});
    rd_chk(BOMT_ADDR_STAT, 8'h00);
  endtask
  // One message under codeword priority, counted on the far side
  task automatic tx_case(input logic [1:0] len, input logic [5:0] code, input int npat);
    int pats;
    int irqs;
    pats = far.n_pat;
    irqs = n_tx_irq;
    wr(BOMT_ADDR_CTRL, {4'h0, len, BOMT_MODE_CW_PRIO});
    wr(BOMT_ADDR_TXCW, {2'b00, code});
    cyc(6);
    `CHK("tx_irq", irqs + 1, n_tx_irq)
    `CHK("link_hold", 1'b1, link_hold)
    rd_chk(BOMT_ADDR_STAT, 8'h80);
    cyc(34);
    `CHK("link_abort", 1'b1, link_abort)
    tx_wait();
    cyc(12);
    `CHK("patterns", npat, far.n_pat - pats)
    `CHK("code", code, far.last_code)
    `CHK("link_hold", 1'b0, link_hold)
    `CHK("link_abort", 1'b0, link_abort)
    // Compare where the link bit has stood a whole bit time
    while (tx_bit_en !== 1'b1) @(posedge sys_clk);
    `CHK("tx_bit", link_tx_bit, tx_bit)
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int base;
    int pats;
    cpu = '0;
    rst = 1'b1;
    link_buf_empty = 1'b1;
    link_idle = 1'b1;
    report_pending = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values, read-only and unmapped places
    rd_chk(BOMT_ADDR_CTRL, BOMT_CTRL_RESET);
    rd_chk(BOMT_ADDR_TXCW, 8'h00);
    wr(BOMT_ADDR_CTRL, 8'h5A);
    wr(BOMT_ADDR_STAT, 8'hFF);
    wr(BOMT_ADDR_RXCW, 8'hFF);
    wr(8'hA5, 8'hFF);
    rd_chk(BOMT_ADDR_CTRL, 8'h5A);
    rd_chk(BOMT_ADDR_STAT, 8'h00);
    rd_chk(BOMT_ADDR_RXCW, 8'h00);
    rd_chk(8'hA5, 8'h00);
    // Receive thresholds with and without integration
    rx_case(8'h80, 6'h01, 1);
    rx_case(8'h90, 6'h02, 10);
    rx_case(8'hA0, 6'h03, 25);
    rx_case(8'hC0, 6'h04, 2);
    rx_case(8'hD0, 6'h05, 11);
    rx_case(8'hE0, 6'h06, 26);
    // Integration: a gap restarts the count
    wr(BOMT_ADDR_CTRL, 8'hD0);
    base = n_rx_irq;
    far.push(6'h0B, 10, 3);
    far.push(6'h0B, 1, 5);
    far.push(6'h0B, 10, 0);
    far.wait_left(156);
    `CHK("rx_irq", base, n_rx_irq)
    far.wait_left(0);
    cyc(8);
    `CHK("rx_irq", base + 1, n_rx_irq)
    rd_chk(BOMT_ADDR_RXCW, 8'h4B);
    // No integration: gaps allowed, a foreign code restarts
    wr(BOMT_ADDR_CTRL, 8'h90);
    base = n_rx_irq;
    far.push(6'h0D, 5, 3);
    far.push(6'h0E, 1, 3);
    far.push(6'h0D, 9, 7);
    far.wait_left(0);
    cyc(8);
    `CHK("rx_irq", base, n_rx_irq)
    far.push(6'h0D, 1, 9);
    far.wait_left(0);
    cyc(8);
    `CHK("rx_irq", base + 1, n_rx_irq)
    rd_chk(BOMT_ADDR_RXCW, 8'h4D);
    // Update on change, overwrite before read
    wr(BOMT_ADDR_CTRL, 8'hB0);
    far.push(6'h21, 3, 3);
    far.push(6'h22, 1, 0);
    far.wait_left(0);
    cyc(8);
    `CHK("rx_irq", base + 3, n_rx_irq)
    rd_chk(BOMT_ADDR_RXCW, 8'hE2);
    rd_chk(BOMT_ADDR_RXCW, 8'h22);
    // Receiver off
    wr(BOMT_ADDR_CTRL, 8'h00);
    far.push(6'h2A, 2, 3);
    far.wait_left(0);
    cyc(8);
    `CHK("rx_irq", base + 3, n_rx_irq)
    rd_chk(BOMT_ADDR_RXCW, 8'h22);
    // Transmit lengths, then a write right after the start pulse
    tx_case(BOMT_LEN_1, 6'h15, 1);
    tx_case(BOMT_LEN_10, 6'h2A, 10);
    tx_case(BOMT_LEN_25, 6'h3F, 25);
    pats = far.n_pat;
    wr(BOMT_ADDR_CTRL, 8'h02);
    wr(BOMT_ADDR_TXCW, 8'h11);
    cyc(6);
    wr(BOMT_ADDR_TXCW, 8'h12);
    wait_pats(pats + 2);
    tx_wait();
    cyc(12);
    `CHK("patterns", pats + 2, far.n_pat)
    `CHK("code", 6'h12, far.last_code)
    // Disabled mode ignores writes
    base = n_tx_irq;
    pats = far.n_pat;
    wr(BOMT_ADDR_CTRL, 8'h01);
    wr(BOMT_ADDR_TXCW, 8'h33);
    cyc(200);
    `CHK("tx_irq", base, n_tx_irq)
    `CHK("patterns", pats, far.n_pat)
    // Link priority: wait for empty idle link, reports go first
    link_buf_empty <= 1'b0;
    link_idle <= 1'b0;
    wr(BOMT_ADDR_CTRL, 8'h03);
    wr(BOMT_ADDR_TXCW, 8'h24);
    cyc(200);
    `CHK("link_hold", 1'b0, link_hold)
    link_buf_empty <= 1'b1;
    cyc(200);
    `CHK("patterns", pats, far.n_pat)
    link_idle <= 1'b1;
    report_pending <= 1'b1;
    cyc(200);
    `CHK("patterns", pats, far.n_pat)
    report_pending <= 1'b0;
    wait_pats(pats + 1);
    tx_wait();
    cyc(12);
    `CHK("patterns", pats + 1, far.n_pat)
    `CHK("code", 6'h24, far.last_code)
    // Continuous sending yields whole patterns, ends on a length change
    pats = far.n_pat;
    wr(BOMT_ADDR_CTRL, 8'h0E);
    wr(BOMT_ADDR_TXCW, 8'h2C);
    cyc(300);
    report_pending <= 1'b1;
    for (int i = 0; i < 80 && link_hold !== 1'b0; i++) @(posedge sys_clk);
    cyc(12);
    `CHK("link_hold", 1'b0, link_hold)
    `CHK("flags", far.n_flag, far.n_pat)
    report_pending <= 1'b0;
    wr(BOMT_ADDR_CTRL, 8'h02);
    tx_wait();
    cyc(12);
    `CHK("patterns", 1'b1, (far.n_pat - pats) >= 4)
    `CHK("flags", far.n_flag, far.n_pat)
    final_report();
  end
endmodule // tb_bomt_transceiver
